// ==== dv/bus_address_match_slice_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_address_match_slice_tb
   import addr_match_pkg::*;
;
   // Bench-driven inputs
   logic       clock = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] addr  = 8'h00;
   logic [7:0] dLow  = 8'h5a;
   logic [7:0] dHigh = 8'hc3;
   logic       fc    = SOURCE_DMA;
   logic       lEn_n = 1'b0;   // Lowest slice of a chain
   logic       bEn_n = 1'b0;
   logic       lStep = 1'b0;
   logic       bStep = 1'b0;
   // Design and model outputs
   logic [7:0] ldat, d64Out, lOut, bCount;
   logic       sel, reqN, strobe, match_n, lCarry_n, bCarry_n;
   int         err_total = 0;
   int         tests_run = 0;
   // Rows: pattern, mask, address, expected match level
   logic [31:0] rows [7] = '{32'ha5_00_a5_00, 32'ha5_00_a4_01, 32'ha5_01_a4_00, 32'ha5_0f_5a_01,
                             32'ha5_ff_5a_00, 32'h00_80_80_00, 32'h00_80_40_01};

   always #4 clock = ~clock;

   bus_address_match_slice i_bus_address_match_slice (
      .clock(clock), .reset(reset), .backplaneAddr(addr), .addr_match_out_n(match_n),
      .local_data_bus(ldat), .register_select(sel), .bus_request_select_n(reqN), .loadStrobe(strobe),
      .d64DataLow(dLow), .d64DataHigh(dHigh), .d64AddrOut_reg(d64Out), .function_code_bit1(fc),
      .local_count_en_in_n(lEn_n), .backplane_count_en_in_n(bEn_n), .localStep(lStep),
      .backplaneStep(bStep), .local_carry_out_n(lCarry_n), .backplane_carry_out_n(bCarry_n),
      .localAddrOut_reg(lOut), .backplaneCount(bCount));

   host_load_model i_host_load_model (
      .clock(clock), .localData(ldat), .registerSelect(sel), .busRequestSel_n(reqN), .loadStrobe(strobe));

   // One comparison, counted; a mismatch is reported at once
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("Counts: %0d compares, %0d mismatches", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Pattern first, since that write clears the mask
   task automatic setup(input logic [7:0] p, input logic [7:0] m);
      i_host_load_model.load(SELECT_PATTERN, p, 1'b1, 1'b0);
      i_host_load_model.load(SELECT_MASK, m, 1'b1, 1'b0);
   endtask

   // Address goes through two sync flops and the output flop
   task automatic probe(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clock) #1 addr = a;
      repeat (5) @(posedge clock);
      #1 chk({7'h0, match_n}, exp, what);   // Sampled once settled
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      #1 reset = 1'b0;
      repeat (2) @(posedge clock);
      #1 chk({lCarry_n, bCarry_n, 6'h0}, {CARRY_IDLE_N, CARRY_IDLE_N, 6'h0}, "carry idle");
      chk(lOut | bCount, COUNT_RESET, "count reset");
      $display("Reset test done");
      foreach (rows[i]) begin
         setup(rows[i][31:24], rows[i][23:16]);
         probe(rows[i][15:8], rows[i][7:0], "row");
      end
      chk(d64Out, dLow, "mux low");
      $display("Table done");
      // Pattern rewrite must clear an all-ignore mask
      setup(8'h3c, MASK_ALL_IGNORE);
      i_host_load_model.load(SELECT_PATTERN, 8'h3c, 1'b1, 1'b0);
      probe(8'h00, 8'h01, "mask cleared");
      chk(d64Out, dHigh, "mux high");
      // Load with request select active is ignored
      i_host_load_model.load(SELECT_MASK, MASK_ALL_IGNORE, 1'b0, 1'b0);
      probe(8'h00, 8'h01, "refused load");
      // Select turned over after the fall must not retarget
      setup(8'h3c, MASK_ALL_IGNORE);
      i_host_load_model.load(SELECT_PATTERN, 8'h00, 1'b1, 1'b1);
      probe(8'h00, 8'h00, "fall select");
      $display("Register cases done");
      // Run both counters to the top
      @(posedge clock) #1 lStep = 1'b1;
      bStep = 1'b1;
      repeat (255) @(posedge clock);
      #1 lStep = 1'b0;
      bStep = 1'b0;
      repeat (5) @(posedge clock);
      #1 chk(lOut, COUNT_MAX, "local top");
      chk({7'h0, lCarry_n}, 8'h00, "local carry top");
      chk(bCount, COUNT_MAX, "backplane top");
      chk({7'h0, bCarry_n}, 8'h00, "backplane carry top");
      // Local permit withdrawn, backplane still wraps
      lEn_n = 1'b1;
      lStep = 1'b1;
      bStep = 1'b1;
      @(posedge clock) #1 lStep = 1'b0;
      bStep = 1'b0;
      repeat (5) @(posedge clock);
      #1 chk(lOut, COUNT_MAX, "local held");
      chk(bCount, COUNT_RESET, "backplane wrap");
      chk({7'h0, bCarry_n}, {7'h0, CARRY_IDLE_N}, "backplane carry wrap");
      fc = ~SOURCE_DMA;
      repeat (4) @(posedge clock);
      #1 chk(lOut, COUNT_RESET, "slave source");
      chk({7'h0, lCarry_n}, {7'h0, CARRY_IDLE_N}, "slave carry");
      fc = SOURCE_DMA;
      $display("Counter cases done");
      // Second reset in mid-run
      reset = 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(lOut, COUNT_RESET, "mid reset count");
      chk({6'h0, match_n, lCarry_n}, {6'h0, MATCH_IDLE_N, CARRY_IDLE_N}, "mid reset outputs");
      reset = 1'b0;
      // Comparator registers survive reset: pattern 00, mask 00 still match
      probe(8'h00, 8'h00, "registers kept");
      $display("Mid-run reset done");
      tally_and_finish();
   end

   // Watchdog well past the expected run length
   initial begin
      #(20000 * 8);
      err_total++;
      $display("BAD t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== dv/host_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_load_model (
   // Clock
   input  wire logic       clock,
   // Load port toward the slice
   output logic [7:0]      localData,
   output logic            registerSelect,
   output logic            busRequestSel_n,
   output logic            loadStrobe
);
   // Idle bus: strobe high, request select inactive
   initial begin
      localData       = 8'h00;
      registerSelect  = 1'b0;
      busRequestSel_n = 1'b1;
      loadStrobe      = 1'b1;
   end

   // One load cycle; flip turns the select over after the fall
   task automatic load(input logic sel, input logic [7:0] d, input logic reqN, input logic flip);
      @(posedge clock) #1;
      registerSelect  = sel;
      busRequestSel_n = reqN;
      loadStrobe      = 1'b0;
      repeat (3) @(posedge clock);
      #1 registerSelect = sel ^ flip;
      localData = d;
      repeat (2) @(posedge clock);
      #1 loadStrobe = 1'b1;
      repeat (4) @(posedge clock);
      // Hold time over: stale data must not look valid
      #1 localData = ~d;
      busRequestSel_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== src/addr_match_pkg.sv ====
package addr_match_pkg;
   // Slice geometry
   localparam int          SLICE_BITS      = 8;
   localparam int          SYNC_STAGES     = 2;
   // Reset and constant values
   localparam logic [7:0]  COUNT_RESET     = 8'h00;
   localparam logic [7:0]  COUNT_MAX       = 8'hff;
   localparam logic [7:0]  MASK_ALL_ENABLE = 8'h00;
   localparam logic [7:0]  MASK_ALL_IGNORE = 8'hff;
   localparam logic        MATCH_IDLE_N    = 1'b1;
   localparam logic        CARRY_IDLE_N    = 1'b1;
   // Register select encoding at the falling strobe edge
   localparam logic        SELECT_PATTERN  = 1'b1;
   localparam logic        SELECT_MASK     = 1'b0;
   // Function code encoding for the local address source
   localparam logic        SOURCE_DMA      = 1'b1;
endpackage

// ==== src/bus_address_match_slice.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_address_match_slice
   import addr_match_pkg::*;
#(
   parameter int WIDTH = SLICE_BITS
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Backplane side
   input  wire logic [WIDTH-1:0] backplaneAddr,
   output logic                  addr_match_out_n,
   // Register load port
   input  wire logic [WIDTH-1:0] local_data_bus,
   input  wire logic             register_select,
   input  wire logic             bus_request_select_n,
   input  wire logic             loadStrobe,
   // 64-bit transfer multiplexer
   input  wire logic [WIDTH-1:0] d64DataLow,
   input  wire logic [WIDTH-1:0] d64DataHigh,
   output logic [WIDTH-1:0]      d64AddrOut_reg,
   // Counter chains
   input  wire logic             function_code_bit1,
   input  wire logic             local_count_en_in_n,
   input  wire logic             backplane_count_en_in_n,
   input  wire logic             localStep,
   input  wire logic             backplaneStep,
   output logic                  local_carry_out_n,
   output logic                  backplane_carry_out_n,
   output logic [WIDTH-1:0]      localAddrOut_reg,
   output logic [WIDTH-1:0]      backplaneCount
);
   initial begin
      if (WIDTH != SLICE_BITS) begin
         $error("bus_address_match_slice WIDTH must equal SLICE_BITS");
      end
   end

   logic [WIDTH-1:0] addrSync1,  addrSync2;
   logic [WIDTH-1:0] dataSync1,  dataSync2;
   logic [WIDTH-1:0] lowSync1,   lowSync2;
   logic [WIDTH-1:0] highSync1,  highSync2;
   logic [7:0]       ctlSync1,   ctlSync2;
   logic             strobePrev;
   logic             strobeFall, strobeRise;
   logic             selectLatched, busReqLatched_n;
   logic [WIDTH-1:0] mask_reg,   pattern_reg;
   logic             matchNow;
   logic             patternSeen_reg;
   logic [WIDTH-1:0] dmaCount,   slaveCount;
   logic             dmaAtMax,   slaveAtMax, backplaneAtMax;
   logic             fcSync, selSync, busReqSync_n, strobeSync;
   logic             localEnSync_n, backplaneEnSync_n, localStepSync, backplaneStepSync;

   // Two-flop synchronisers on every pin input except clock and reset
   always_ff @(posedge clock) begin
      addrSync1 <= backplaneAddr;
      addrSync2 <= addrSync1;
      dataSync1 <= local_data_bus;
      dataSync2 <= dataSync1;
      lowSync1  <= d64DataLow;
      lowSync2  <= lowSync1;
      highSync1 <= d64DataHigh;
      highSync2 <= highSync1;
      ctlSync1  <= {register_select, bus_request_select_n, loadStrobe, function_code_bit1,
                    local_count_en_in_n, backplane_count_en_in_n, localStep, backplaneStep};
      ctlSync2  <= ctlSync1;
   end

   assign {selSync, busReqSync_n, strobeSync, fcSync,
           localEnSync_n, backplaneEnSync_n, localStepSync, backplaneStepSync} = ctlSync2;

   // Strobe edge detection on the second stage only
   always_ff @(posedge clock) begin
      if (reset) begin
         strobePrev <= 1'b1;
      end else begin
         strobePrev <= strobeSync;
      end
   end

   assign strobeFall = strobePrev & ~strobeSync;
   assign strobeRise = ~strobePrev & strobeSync;

   // Address of the load captured at the falling edge
   always_ff @(posedge clock) begin
      if (reset) begin
         selectLatched   <= SELECT_MASK;
         busReqLatched_n <= 1'b1;
      end else if (strobeFall) begin
         selectLatched   <= selSync;
         busReqLatched_n <= busReqSync_n;
      end
   end

   // Comparator registers: no reset, unknown until programmed, never read back
   always_ff @(posedge clock) begin
      if (strobeRise && busReqLatched_n) begin
         if (selectLatched == SELECT_PATTERN) begin
            pattern_reg <= dataSync2;
            mask_reg    <= MASK_ALL_ENABLE;
         end else begin
            mask_reg    <= dataSync2;
         end
      end
   end

   // Checker helper; both registers are known once a pattern write has landed
   always_ff @(posedge clock) begin
      if (reset) begin
         patternSeen_reg <= 1'b0;
      end else if (strobeRise && busReqLatched_n && (selectLatched == SELECT_PATTERN)) begin
         patternSeen_reg <= 1'b1;
      end
   end

   // Bitwise equality; a set mask bit forces that position to match
   assign matchNow = &((addrSync2 ~^ pattern_reg) | mask_reg);

   // Registered output removes the settling glitches, at one cycle of latency
   always_ff @(posedge clock) begin
      if (reset) begin
         addr_match_out_n <= MATCH_IDLE_N;
      end else begin
         addr_match_out_n <= ~matchNow;
      end
   end

   // Data-to-address multiplexer for 64-bit transfers
   always_ff @(posedge clock) begin
      if (reset) begin
         d64AddrOut_reg <= COUNT_RESET;
      end else begin
         d64AddrOut_reg <= selSync ? highSync2 : lowSync2;
      end
   end

   // Shared local chain: function code routes the enable to one counter
   count_slice #(.WIDTH(WIDTH)) dmaCounter (
      .clock         (clock),
      .reset         (reset),
      .countEnable_n (localEnSync_n | (fcSync != SOURCE_DMA)),
      .step          (localStepSync),
      .count_reg     (dmaCount),
      .atMax         (dmaAtMax)
   );

   count_slice #(.WIDTH(WIDTH)) slaveCounter (
      .clock         (clock),
      .reset         (reset),
      .countEnable_n (localEnSync_n | (fcSync == SOURCE_DMA)),
      .step          (localStepSync),
      .count_reg     (slaveCount),
      .atMax         (slaveAtMax)
   );

   count_slice #(.WIDTH(WIDTH)) backplaneCounter (
      .clock         (clock),
      .reset         (reset),
      .countEnable_n (backplaneEnSync_n),
      .step          (backplaneStepSync),
      .count_reg     (backplaneCount),
      .atMax         (backplaneAtMax)
   );

   // Local address source and carry outputs
   always_ff @(posedge clock) begin
      if (reset) begin
         localAddrOut_reg      <= COUNT_RESET;
         local_carry_out_n     <= CARRY_IDLE_N;
         backplane_carry_out_n <= CARRY_IDLE_N;
      end else begin
         localAddrOut_reg      <= (fcSync == SOURCE_DMA) ? dmaCount : slaveCount;
         local_carry_out_n     <= ~((fcSync == SOURCE_DMA) ? dmaAtMax : slaveAtMax);
         backplane_carry_out_n <= ~backplaneAtMax;
      end
   end

   // Checks
   a_match_follows_compare: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $past(patternSeen_reg) |-> addr_match_out_n == !$past(matchNow))
      else $error("match output does not follow comparison");

   a_mask_all_ignore: assert property (@(posedge clock) disable iff (reset)
      (mask_reg == MASK_ALL_IGNORE) ##1 (mask_reg == MASK_ALL_IGNORE) |-> !addr_match_out_n)
      else $error("all-ones mask did not force match");

   a_select_capture: assert property (@(posedge clock) disable iff (reset)
      strobeFall |=> selectLatched == $past(selSync) && busReqLatched_n == $past(busReqSync_n))
      else $error("selects not captured at strobe fall");

   a_pattern_load: assert property (@(posedge clock) disable iff (reset)
      strobeRise && busReqLatched_n && selectLatched |=>
         pattern_reg == $past(dataSync2) && mask_reg == MASK_ALL_ENABLE)
      else $error("pattern load or mask clear wrong");

   a_mask_load: assert property (@(posedge clock) disable iff (reset)
      strobeRise && busReqLatched_n && !selectLatched |=>
         mask_reg == $past(dataSync2) && $stable(pattern_reg))
      else $error("mask load wrong");

   a_no_load_busreq: assert property (@(posedge clock) disable iff (reset)
      patternSeen_reg && (!strobeRise || !busReqLatched_n) |=> $stable(mask_reg) && $stable(pattern_reg))
      else $error("comparator register changed outside a load");

   a_match_after_load: assert property (@(posedge clock) disable iff (reset)
      strobeRise && busReqLatched_n ##1 1'b1 |=> addr_match_out_n == !$past(matchNow))
      else $error("match output late after load");

   a_count_gated: assert property (@(posedge clock) disable iff (reset)
      localEnSync_n || !localStepSync |=> $stable(dmaCount) && $stable(slaveCount))
      else $error("local counter moved without enable and step");

   a_local_carry: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) |-> local_carry_out_n == !$past(fcSync ? dmaAtMax : slaveAtMax))
      else $error("local carry wrong");

   a_source_select: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) |-> localAddrOut_reg == $past(fcSync ? dmaCount : slaveCount))
      else $error("local address source wrong");

   c_pattern_load: cover property (@(posedge clock) disable iff (reset)
      strobeRise && busReqLatched_n && selectLatched);
   c_mask_load: cover property (@(posedge clock) disable iff (reset)
      strobeRise && busReqLatched_n && !selectLatched);
   c_match_seen: cover property (@(posedge clock) disable iff (reset)
      addr_match_out_n ##1 !addr_match_out_n);
   c_local_carry: cover property (@(posedge clock) disable iff (reset)
      !local_carry_out_n);
endmodule
`default_nettype wire

// ==== src/count_slice.sv ====
`timescale 1ns/1ps
`default_nettype none
module count_slice
   import addr_match_pkg::*;
#(
   parameter int WIDTH = SLICE_BITS
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Count control
   input  wire logic             countEnable_n,
   input  wire logic             step,
   // State
   output logic [WIDTH-1:0]      count_reg,
   output logic                  atMax
);
   initial begin
      if (WIDTH < 1 || WIDTH > SLICE_BITS) begin
         $error("count_slice WIDTH out of range");
      end
   end

   // Enable only permits counting; the step pulse advances
   always_ff @(posedge clock) begin
      if (reset) begin
         count_reg <= COUNT_RESET[WIDTH-1:0];
      end else if (!countEnable_n && step) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   assign atMax = (count_reg == COUNT_MAX[WIDTH-1:0]);
endmodule
`default_nettype wire
